/* rst_pm_pkg.sv */
package rst_pm_pkg;

  // Sequence length in half-clock periods and in CPU cycles.
  localparam int SEQ_HALF_CLOCKS = 1024;
  localparam int SEQ_CYCLES = SEQ_HALF_CLOCKS / 2;
  localparam int TRANS_CYCLES = 4;
  localparam int CNT_W = 10;

  // Register word offsets.
  localparam logic [3:0] OFS_SYS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_COMMAND = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Field positions.
  localparam int CFG_READY_HIGH_BIT = 0;
  localparam int CFG_PD_EXT_ONLY_BIT = 1;
  localparam int CFG_BIDIR_BIT = 3;
  localparam int CMD_SW_RESET_BIT = 0;
  localparam int CMD_IDLE_BIT = 1;
  localparam int CMD_PDOWN_BIT = 2;
  localparam int STS_REFUSED_BIT = 8;
  localparam int STS_CAUSE_LSB = 9;

  // Reset values.
  localparam logic CFG_BIDIR_RST = 1'b0;
  localparam logic CFG_READY_HIGH_RST = 1'b0;
  localparam logic CFG_PD_EXT_RST = 1'b0;

  // Reset causes.
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_COLD = 3'h1;
  localparam logic [2:0] CAUSE_WARM = 3'h2;
  localparam logic [2:0] CAUSE_SOFT = 3'h3;
  localparam logic [2:0] CAUSE_WDOG = 3'h4;

  // Pending low-power requests.
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_IDLE = 2'h1;
  localparam logic [1:0] REQ_PDOWN = 2'h2;

  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_IDLE = 8'h02,
    ST_PDOWN = 8'h04,
    ST_HELD = 8'h08,
    ST_TRANS = 8'h10,
    ST_WDOG = 8'h20,
    ST_SEQ = 8'h40,
    ST_EXTEND = 8'h80
  } seq_state_type;

endpackage

/* reset_edge_sync.sv */
`timescale 1ns/1ps
module reset_edge_sync (
  // Clock.
  input wire logic clk_in,
  // Active-low reset level.
  input wire logic pin_n_in,
  // Reset active, set at once and released after two edges.
  output logic active_out
);

  typedef struct packed {
    logic meta;
    logic act;
  } sync_type;

  sync_type r;
  sync_type next_r;

  // Release shifts through; the first stage feeds only the second.
  always_comb begin
    next_r.meta = 1'b0;
    next_r.act = r.meta;
  end

  // Entry is asynchronous, exit waits for the clock.
  always_ff @(posedge clk_in or negedge pin_n_in) begin
    if (!pin_n_in) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign active_out = r.act;

endmodule

/* reset_and_power_mode_sequencer.sv */
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module reset_and_power_mode_sequencer (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic software_reset_instruction_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  // Reset pin, open drain, and status pins.
  input wire logic reset_input_pin_in,
  output logic reset_input_pin_oe_n_out,
  output logic reset_output_pin_out,
  input wire logic vpp_high_in,
  // Watchdog and mode.
  input wire logic watchdog_overflow_in,
  input wire logic bootstrap_mode_in,
  // External bus status.
  input wire logic bus_cycle_active_in,
  input wire logic bus_uses_ready_in,
  input wire logic waitstates_done_in,
  input wire logic ready_in,
  input wire logic ready_enabled_in,
  // Wake sources.
  input wire logic interrupt_req_in,
  input wire logic fast_ext_int_in,
  // Controls to the rest of the chip.
  output logic internal_reset_out,
  output logic io_hiz_out,
  output logic hold_cancel_out,
  output logic bus_abort_out,
  output logic cpu_stop_out,
  output logic periph_stop_out
);
  import rst_pm_pkg::*;

  localparam int SEQ_LAST = SEQ_CYCLES - 1;

  typedef struct packed {
    seq_state_type state;
    logic [CNT_W-1:0] count;
    logic cfg_bidir;
    logic cfg_ready_high;
    logic cfg_pd_ext;
    logic [1:0] mode_req;
    logic refused;
    logic [2:0] cause;
    logic bidir_latched;
    logic ready_seen;
    logic bus_prev;
    logic w_pend;
    logic [3:0] w_ofs;
    logic w_mapped;
    logic [31:0] rdata;
    logic pin_oe_n;
    logic reset_output_pin;
    logic int_reset;
    logic hold_cancel;
    logic bus_abort;
    logic cpu_stop;
    logic periph_stop;
  } core_type;

  core_type r;
  core_type next_r;
  logic pin_active;
  logic pin_n_eff;
  logic ready_active;
  logic addr_ok;

  // Own drive of the pin must not look like an external reset. The mask stays on
  // through the extension state, so that neither the slow rise after the drive is
  // let go nor the pin lagging its enable can be taken for a fresh reset.
  assign pin_n_eff = reset_input_pin_in | ~r.pin_oe_n | (r.state == ST_EXTEND);

  reset_edge_sync u_pin_sync (
    .clk_in(clk_in),
    .pin_n_in(pin_n_eff),
    .active_out(pin_active)
  );

  // Ready level honours the programmed polarity.
  assign ready_active = (ready_in == r.cfg_ready_high);
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;

  // Next-state, register and output logic.
  always_comb begin
    next_r = r;
    next_r.bus_abort = 1'b0;
    next_r.bus_prev = bus_cycle_active_in;
    next_r.w_pend = 1'b0;

    // Track whether ready went active during the latest bus access.
    if (bus_cycle_active_in && !r.bus_prev) begin
      next_r.ready_seen = ready_active;
    end else if (bus_cycle_active_in && ready_active) begin
      next_r.ready_seen = 1'b1;
    end

    // Register writes land in the data phase.
    if (r.w_pend && r.w_mapped) begin
      if (r.w_ofs == OFS_SYS_CONFIG) begin
        next_r.cfg_bidir = hwdata_in[CFG_BIDIR_BIT];
        next_r.cfg_ready_high = hwdata_in[CFG_READY_HIGH_BIT];
        next_r.cfg_pd_ext = hwdata_in[CFG_PD_EXT_ONLY_BIT];
      end else if (r.w_ofs == OFS_COMMAND) begin
        if (hwdata_in[CMD_SW_RESET_BIT] && r.state == ST_RUN) begin
          next_r.state = ST_TRANS;
          next_r.count = '0;
          next_r.cause = CAUSE_SOFT;
          next_r.bus_abort = 1'b1;
          next_r.mode_req = REQ_NONE;
        end else if (hwdata_in[CMD_PDOWN_BIT]) begin
          next_r.mode_req = REQ_PDOWN;
        end else if (hwdata_in[CMD_IDLE_BIT]) begin
          next_r.mode_req = REQ_IDLE;
        end
      end else if (r.w_ofs == OFS_STATUS) begin
        if (hwdata_in[STS_REFUSED_BIT]) begin
          next_r.refused = 1'b0;
        end
      end
    end

    // Sequencer; an external pin reset outranks every state but the extension state.
    if (pin_active && r.state != ST_HELD && r.state != ST_EXTEND) begin
      next_r.state = ST_HELD;
      next_r.mode_req = REQ_NONE;
      next_r.cause = vpp_high_in ? CAUSE_WARM : CAUSE_COLD;
    end else begin
      case (r.state)
        ST_RUN: begin
          if (watchdog_overflow_in && !bootstrap_mode_in) begin
            next_r.state = ST_WDOG;
            next_r.cause = CAUSE_WDOG;
            next_r.mode_req = REQ_NONE;
          end else if (next_r.state == ST_RUN && r.mode_req != REQ_NONE &&
                       !bus_cycle_active_in) begin
            next_r.mode_req = REQ_NONE;
            if (ready_enabled_in && !r.ready_seen) begin
              next_r.refused = 1'b1;
            end else if (r.mode_req == REQ_PDOWN) begin
              next_r.state = ST_PDOWN;
            end else begin
              next_r.state = ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          if (watchdog_overflow_in && !bootstrap_mode_in) begin
            next_r.state = ST_WDOG;
            next_r.cause = CAUSE_WDOG;
          end else if (interrupt_req_in) begin
            next_r.state = ST_RUN;
          end
        end
        ST_PDOWN: begin
          if (fast_ext_int_in || (interrupt_req_in && !r.cfg_pd_ext)) begin
            next_r.state = ST_RUN;
          end
        end
        ST_HELD: begin
          if (!pin_active) begin
            next_r.count = '0;
            next_r.bus_abort = 1'b1;
            if (r.cause == CAUSE_WARM) begin
              next_r.state = ST_TRANS;
            end else begin
              next_r.state = ST_SEQ;
              next_r.bidir_latched = r.cfg_bidir;
            end
          end
        end
        ST_TRANS: begin
          next_r.count = r.count + 1'b1;
          if (r.count == CNT_W'(TRANS_CYCLES - 1)) begin
            next_r.state = ST_SEQ;
            next_r.count = '0;
            next_r.bidir_latched = r.cfg_bidir;
          end
        end
        ST_WDOG: begin
          if (!bus_cycle_active_in) begin
            next_r.state = ST_SEQ;
            next_r.count = '0;
            next_r.bidir_latched = r.cfg_bidir;
          end else if (waitstates_done_in && bus_uses_ready_in && !ready_active) begin
            next_r.state = ST_SEQ;
            next_r.count = '0;
            next_r.bus_abort = 1'b1;
            next_r.bidir_latched = r.cfg_bidir;
          end
        end
        ST_SEQ: begin
          next_r.count = r.count + 1'b1;
          if (r.count == CNT_W'(SEQ_LAST)) begin
            next_r.cfg_bidir = 1'b0;
            next_r.bidir_latched = 1'b0;
            next_r.count = '0;
            if (r.bidir_latched || !reset_input_pin_in) begin
              next_r.state = ST_EXTEND;
            end else begin
              next_r.state = ST_RUN;
            end
          end
        end
        ST_EXTEND: begin
          if (reset_input_pin_in) begin
            next_r.state = ST_RUN;
          end
        end
        default: begin
          next_r.state = ST_RUN;
        end
      endcase
    end

    // Outputs follow the next state so they change with it.
    next_r.int_reset = (next_r.state == ST_HELD) || (next_r.state == ST_TRANS) ||
                       (next_r.state == ST_SEQ) || (next_r.state == ST_EXTEND);
    next_r.reset_output_pin = !next_r.int_reset;
    next_r.pin_oe_n = !(next_r.state == ST_SEQ && next_r.bidir_latched);
    next_r.hold_cancel = (next_r.state == ST_TRANS);
    next_r.cpu_stop = (next_r.state == ST_IDLE) || (next_r.state == ST_PDOWN);
    next_r.periph_stop = (next_r.state == ST_PDOWN);

    // Address phase: capture writes and prepare read data.
    if (addr_ok) begin
      next_r.w_pend = hwrite_in;
      next_r.w_ofs = haddr_in[3:0];
      next_r.w_mapped = (haddr_in[31:4] == 28'h0000000) && (haddr_in[1:0] == 2'h0);
      next_r.rdata = 32'h00000000;
      if (!hwrite_in && next_r.w_mapped) begin
        if (haddr_in[3:0] == OFS_SYS_CONFIG) begin
          next_r.rdata[CFG_BIDIR_BIT] = r.cfg_bidir;
          next_r.rdata[CFG_READY_HIGH_BIT] = r.cfg_ready_high;
          next_r.rdata[CFG_PD_EXT_ONLY_BIT] = r.cfg_pd_ext;
        end else if (haddr_in[3:0] == OFS_STATUS) begin
          next_r.rdata[7:0] = r.state;
          next_r.rdata[STS_REFUSED_BIT] = r.refused;
          next_r.rdata[STS_CAUSE_LSB +: 3] = r.cause;
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (software_reset_instruction_in) begin
      r <= '0;
      r.state <= ST_RUN;
      r.cfg_bidir <= CFG_BIDIR_RST;
      r.cfg_ready_high <= CFG_READY_HIGH_RST;
      r.cfg_pd_ext <= CFG_PD_EXT_RST;
      r.mode_req <= REQ_NONE;
      r.cause <= CAUSE_NONE;
      r.pin_oe_n <= 1'b1;
      r.reset_output_pin <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops; hreadyout_out and hresp_out are constants.
  assign hreadyout_out = 1'b1;
  assign hrdata_out = r.rdata;
  assign hresp_out = 1'b0;
  assign reset_input_pin_oe_n_out = r.pin_oe_n;
  assign reset_output_pin_out = r.reset_output_pin;
  assign internal_reset_out = r.int_reset;
  assign io_hiz_out = pin_active;
  assign hold_cancel_out = r.hold_cancel;
  assign bus_abort_out = r.bus_abort;
  assign cpu_stop_out = r.cpu_stop;
  assign periph_stop_out = r.periph_stop;

  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (software_reset_instruction_in);

  a_seq_length: assert property (
    (r.state == ST_SEQ && next_r.state != ST_SEQ && !pin_active) |-> r.count == SEQ_LAST)
    else $error("Reset sequence length wrong.");
  a_bidir_clear: assert property (
    (r.state == ST_SEQ && r.count == SEQ_LAST && !pin_active) |=> !r.cfg_bidir)
    else $error("Bidirectional enable not cleared.");
  a_boot_no_wdog: assert property (
    (r.state == ST_RUN && bootstrap_mode_in && !pin_active) |=> r.state != ST_WDOG)
    else $error("Watchdog reset in bootstrap mode.");
  a_pin_drive: assert property (
    (r.state == ST_SEQ && r.bidir_latched) |-> (!reset_input_pin_oe_n_out && !reset_output_pin_out))
    else $error("Reset pin not driven in sequence.");
  a_idle_wake: assert property (
    (r.state == ST_IDLE && interrupt_req_in && !pin_active && !watchdog_overflow_in)
    |=> r.state == ST_RUN && !cpu_stop_out)
    else $error("Idle did not end on interrupt.");
  a_extend_hold: assert property (
    (r.state == ST_EXTEND && !reset_input_pin_in) |=> (r.state == ST_EXTEND && internal_reset_out))
    else $error("Reset not prolonged.");
  a_pdown_stay: assert property (
    (r.state == ST_PDOWN && r.cfg_pd_ext && !fast_ext_int_in && !pin_active)
    |=> (r.state == ST_PDOWN && periph_stop_out))
    else $error("Power-down left without fast interrupt.");
  a_refuse_idle: assert property (
    (r.state == ST_RUN && r.mode_req != REQ_NONE && !bus_cycle_active_in && ready_enabled_in &&
     !r.ready_seen && !pin_active && !watchdog_overflow_in && !r.w_pend)
    |=> (r.state == ST_RUN && r.refused))
    else $error("Low-power entry not refused.");
  a_wdog_abort: assert property (
    (r.state == ST_WDOG && bus_cycle_active_in && waitstates_done_in && bus_uses_ready_in &&
     !ready_active && !pin_active) |=> (bus_abort_out && r.state == ST_SEQ))
    else $error("Watchdog did not abort cycle.");
  // Pin entry, sequence steps and wake paths.
  a_hiz_entry: assert property (
    !pin_n_eff |-> io_hiz_out)
    else $error("Pins not floated on reset entry.");
  a_held_reset: assert property (
    (pin_active && r.state != ST_EXTEND) |=> (internal_reset_out && !reset_output_pin_out))
    else $error("Pin reset not applied.");
  a_trans_end: assert property (
    (r.state == ST_TRANS && r.count == CNT_W'(TRANS_CYCLES - 1) && !pin_active)
    |=> (r.state == ST_SEQ && internal_reset_out))
    else $error("Transition period length wrong.");
  a_soft_start: assert property (
    (r.w_pend && r.w_mapped && r.w_ofs == OFS_COMMAND && hwdata_in[CMD_SW_RESET_BIT] &&
     r.state == ST_RUN && !pin_active && !watchdog_overflow_in)
    |=> (r.state == ST_TRANS && r.cause == CAUSE_SOFT))
    else $error("Software reset did not start.");
  a_wdog_finish: assert property (
    (r.state == ST_WDOG && bus_cycle_active_in && !pin_active &&
     !(waitstates_done_in && bus_uses_ready_in && !ready_active))
    |=> (r.state == ST_WDOG && !bus_abort_out))
    else $error("Watchdog cut a finishing cycle.");
  a_idle_wdog: assert property (
    (r.state == ST_IDLE && watchdog_overflow_in && !bootstrap_mode_in && !pin_active)
    |=> r.state == ST_WDOG)
    else $error("Idle not left on watchdog reset.");
  a_pd_fast_wake: assert property (
    (r.state == ST_PDOWN && fast_ext_int_in && !pin_active)
    |=> (r.state == ST_RUN && !periph_stop_out))
    else $error("Power-down not left on fast interrupt.");
  a_bus_before_low: assert property (
    (r.state == ST_RUN && bus_cycle_active_in) |=> !cpu_stop_out)
    else $error("Low power entered during bus cycle.");

endmodule

/* board_reset_circuit.sv */
`timescale 1ns/1ps
module board_reset_circuit (
  // Request from the board supervisor to pull the line low.
  input wire logic press_in,
  // Device open-drain enable, low while the device pulls the line.
  input wire logic device_oe_n_in,
  // Resolved line level.
  output logic pin_level_out
);
  // Wired-AND of both pull-downs; the board pull-up wins when nobody drives.
  assign pin_level_out = ~(press_in | ~device_oe_n_in);
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import rst_pm_pkg::*;
  logic clk, software_reset_instruction, hsel, hwr, hrdy, hresp, press, pin, oe_n, rout;
  logic vpp, wdog, boot, bact, buse, wsd, rdy, rden, irq, fint;
  logic irst, hiz, hcan, babort, cstop, pstop;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  int miscompares, tests_run, n, c, ab_cnt, hc_cnt, oe_cnt, ir_cnt;

  // Device under test and the board circuit on its reset line.
  reset_and_power_mode_sequencer reset_and_power_mode_sequencer_i (
    .clk_in(clk), .software_reset_instruction_in(software_reset_instruction), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwr), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(hresp),
    .reset_input_pin_in(pin), .reset_input_pin_oe_n_out(oe_n), .reset_output_pin_out(rout),
    .vpp_high_in(vpp), .watchdog_overflow_in(wdog), .bootstrap_mode_in(boot),
    .bus_cycle_active_in(bact), .bus_uses_ready_in(buse), .waitstates_done_in(wsd),
    .ready_in(rdy), .ready_enabled_in(rden), .interrupt_req_in(irq), .fast_ext_int_in(fint),
    .internal_reset_out(irst), .io_hiz_out(hiz), .hold_cancel_out(hcan),
    .bus_abort_out(babort), .cpu_stop_out(cstop), .periph_stop_out(pstop));
  board_reset_circuit board_reset_circuit_i (
    .press_in(press), .device_oe_n_in(oe_n), .pin_level_out(pin));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counters of pulses and levels that the scenarios clear and inspect.
  always @(posedge clk) begin
    if (babort === 1'b1) ab_cnt <= ab_cnt + 1;
    if (hcan === 1'b1) hc_cnt <= hc_cnt + 1;
    if (oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
    if (irst === 1'b1) ir_cnt <= ir_cnt + 1;
  end

  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic clr;
    @(negedge clk);
    ab_cnt = 0;
    hc_cnt = 0;
    oe_cnt = 0;
    ir_cnt = 0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: sig = irst;
      1: sig = ~oe_n;
      default: sig = cstop;
    endcase
  endfunction

  task automatic wait_sig(input int s, input logic val, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sig(s) !== val && n < lim);
    if (sig(s) !== val) begin
      miscompares++;
      test_done;
    end
  endtask

  task automatic cnt_high(input int s);
    wait_sig(s, 1'b1, 2000);
    c = 0;
    while (sig(s) === 1'b1 && c < 4000) begin
      @(negedge clk);
      c++;
    end
  endtask

  // Waits for hready at a rising edge, bounded.
  task automatic hwait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      miscompares++;
      test_done;
    end
  endtask

  // One single-word transfer: address phase, then data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwr <= w;
    hsize <= 3'h2;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd = hrdata;
  endtask

  task automatic rdcause(input logic [2:0] cause);
    ahb(1'b0, 32'h8, 32'h0);
    check({20'h0, rd[11:0]}, {20'h0, cause, 9'h001});
    check({31'h0, hresp}, 32'h0);
  endtask

  // Main sequence.
  initial begin
    software_reset_instruction = 1'b1;
    {hsel, hwr, press, vpp, wdog, boot, bact, buse, wsd, rdy, rden, irq, fint} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    {miscompares, tests_run, ab_cnt, hc_cnt, oe_cnt, ir_cnt} = '0;
    v = $urandom(30169);
    repeat (6) @(posedge clk);
    software_reset_instruction <= 1'b0;
    ahb(1'b0, 32'h8, 32'h0);
    check(rd & 32'h1ff, 32'h001);
    ahb(1'b0, 32'h0, 32'h0);
    check(rd & 32'hb, 32'h0);
    ahb(1'b0, 32'h4, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    check(rd, 32'h0);
    done("registers");
    for (int w = 0; w < 2; w++) begin
      clr;
      @(posedge clk);
      vpp <= w[0];
      press <= 1'b1;
      #1 check({31'h0, hiz}, 32'h1);
      repeat ($urandom_range(40, 3)) @(posedge clk);
      @(negedge clk);
      check({30'h0, irst, rout}, 32'h2);
      @(posedge clk);
      press <= 1'b0;
      cnt_high(0);
      check({31'h0, c >= SEQ_CYCLES}, 32'h1);
      check(hc_cnt, w ? TRANS_CYCLES : 0);
      check(ab_cnt, 32'h1);
      rdcause(w ? CAUSE_WARM : CAUSE_COLD);
    end
    done("pin reset");
    for (int b = 0; b < 2; b++) begin
      v = $urandom;
      v[3] = b[0];
      v[0] = 1'b0;
      ahb(1'b1, 32'h0, v);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd & 32'hb, v & 32'hb);
      clr;
      ahb(1'b1, 32'h4, 32'h1);
      cnt_high(0);
      check(c, TRANS_CYCLES + SEQ_CYCLES + b);
      check(oe_cnt, b ? SEQ_CYCLES : 0);
      ahb(1'b0, 32'h0, 32'h0);
      check({31'h0, rd[3]}, 32'h0);
      rdcause(CAUSE_SOFT);
    end
    done("software reset");
    clr;
    @(posedge clk);
    boot <= 1'b1;
    wdog <= 1'b1;
    repeat (20) @(posedge clk);
    wdog <= 1'b0;
    boot <= 1'b0;
    check(ir_cnt, 0);
    for (int u = 0; u < 2; u++) begin
      clr;
      @(posedge clk);
      {bact, wsd, rdy, wdog} <= 4'hf;
      buse <= u[0];
      @(posedge clk);
      wdog <= 1'b0;
      repeat (10) @(negedge clk);
      check({30'h0, irst, rout}, u ? 32'h2 : 32'h1);
      check(ab_cnt, u);
      @(posedge clk);
      bact <= 1'b0;
      wait_sig(0, 1'b1, 50);
      wait_sig(0, 1'b0, 2000);
      check(ir_cnt, SEQ_CYCLES);
      rdcause(CAUSE_WDOG);
    end
    done("watchdog");
    ahb(1'b1, 32'h0, 32'h2);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      bact <= 1'b1;
      ahb(1'b1, 32'h4, m ? 32'h4 : 32'h2);
      repeat (10) @(negedge clk);
      check({31'h0, cstop}, 32'h0);
      @(posedge clk);
      bact <= 1'b0;
      wait_sig(2, 1'b1, 50);
      check({30'h0, cstop, pstop}, {30'h0, 1'b1, m[0]});
      @(posedge clk);
      irq <= 1'b1;
      repeat (10) @(negedge clk);
      check({31'h0, cstop}, m);
      @(posedge clk);
      fint <= 1'b1;
      wait_sig(2, 1'b0, 50);
      @(posedge clk);
      {irq, fint} <= 2'h0;
    end
    done("low power");
    @(posedge clk);
    {bact, rden, rdy, wsd} <= 4'hf;
    repeat (5) @(posedge clk);
    bact <= 1'b0;
    ahb(1'b1, 32'h4, 32'h2);
    repeat (10) @(negedge clk);
    check({31'h0, cstop}, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    check({31'h0, rd[8]}, 32'h1);
    ahb(1'b1, 32'h8, 32'h100);
    ahb(1'b0, 32'h8, 32'h0);
    check({31'h0, rd[8]}, 32'h0);
    done("refused entry");
    test_done;
  end
endmodule
